// ---- uart_chan_pkg.sv ----
// Constants, register map and state types of the serial channel.
// Assumes an APB slave at 32-bit words; no other dependency.
package uart_chan_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] data_divider_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] flag_clear_off = 8'h08;
  localparam logic [7:0] start_off = 8'h0c;
  localparam logic [7:0] stop_off = 8'h10;
  localparam logic [7:0] enable_status_off = 8'h14;
  localparam logic [7:0] irq_mask_off = 8'h18;
  localparam logic [7:0] irq_status_off = 8'h1c;

  // ==========================================================
  // Field positions
  localparam int divider_lsb = 9;
  localparam int divider_msb = 15;
  localparam int overrun_bit = 0;
  localparam int framing_bit = 1;
  localparam int parity_bit = 2;
  localparam int full_bit = 5;
  localparam int tx_busy_bit = 6;

  // Interrupt status bits
  localparam int irq_rx_bit = 0;
  localparam int irq_tx_bit = 1;
  localparam int irq_err_bit = 2;

  // ==========================================================
  // Reset values
  localparam logic [6:0] divider_reset = 7'h4d;
  localparam logic [2:0] irq_mask_reset = 3'h0;
  localparam logic enable_reset = 1'b0;

  // Divider field 0 and 1 are unusable; the count needs k of at least 3
  localparam logic [6:0] divider_min = 7'h02;

  typedef enum logic [1:0] {
    rx_idle, rx_start, rx_bits, rx_stop
  } rx_state_type;

  typedef enum logic [1:0] {
    tx_idle, tx_shift
  } tx_state_type;

endpackage

// ---- bit_timer_if.sv ----
// Carrier between the main channel and its bit timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface bit_timer_if;
  logic [6:0] divider;
  logic restart;
  logic half_tick;
  logic tick;
  modport owner (output divider, output restart, input half_tick,
    input tick);
  modport timer (input divider, input restart, output half_tick,
    output tick);
endinterface
`default_nettype wire

// ---- bit_timer.sv ----
// Bit timer: one bit lasts 2*(divider+1) operation clocks.
// Assumes the operation clock enable arrives as op_tick_i.
`timescale 1ns/1ps
`default_nettype none
module bit_timer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic op_tick_i,
  bit_timer_if.timer t
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] cnt;
  } state_type;
  state_type s_q, s_d;
  logic [7:0] period;

  always_comb begin
    period = {t.divider, 1'b1};
    s_d = s_q;
    t.tick = 1'b0;
    t.half_tick = 1'b0;
    if (t.restart) begin
      s_d.cnt = 8'h00;
    end else if (op_tick_i) begin
      // Sample point sits at mid bit, k clocks
      t.half_tick = (s_q.cnt == {1'b0, t.divider});
      if (s_q.cnt == period) begin
        s_d.cnt = 8'h00;
        t.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ---- shift_frame.sv ----
// Frame shifter shared by the receive and transmit paths.
// Assumes shift_i is a one-cycle strobe on the main clock.
`timescale 1ns/1ps
`default_nettype none
module shift_frame #(
  parameter int width = 9
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [width-1:0] load_data_i,
  input wire logic shift_i,
  input wire logic bit_i,
  output logic [width-1:0] data_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [width-1:0] sr;
  } state_type;
  state_type s_q, s_d;

  initial begin
    if (width < 2) begin
      $error("shift_frame width too small");
    end
  end

  always_comb begin
    s_d = s_q;
    if (load_i) begin
      s_d.sr = load_data_i;
    end else if (shift_i) begin
      // LSB first on the line
      s_d.sr = {bit_i, s_q.sr[width-1:1]};
    end
  end

  assign data_o = s_q.sr;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ---- uart_chan.sv ----
// Asynchronous serial channel with APB registers and error recovery.
// Assumes an APB master on clk_i and an operation clock strobe.
// Functional notes
// - Bit rate is fop over k, halved
// - Rate error is generated over target, percent
// - Receiver accepts rates within the tolerance bounds
// - k is divider plus one; N frame bits
// - Receive sampling timed from divider bits 15:9
// - Data read clears full flag, rearms receive
// - Ones written to flag clear clear errors
// - Stop trigger clears enable status, halts channel
// - Start trigger sets enable status, runs channel
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module uart_chan #(
  parameter int data_bits = 8,
  parameter bit parity_en = 1'b1,
  parameter bit parity_odd = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic op_tick_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_i,
  output logic txd_o,
  output logic irq_o
);

  localparam int fw = data_bits + 1;

  initial begin
    if (data_bits < 5 || data_bits > 9) begin
      $error("uart_chan data_bits out of range");
    end
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0] rx_sync;
    logic rx_line;
    uart_chan_pkg::rx_state_type rx_st;
    logic [3:0] rx_cnt;
    logic rx_par;
    logic [8:0] rx_buf;
    logic full;
    logic ovf;
    logic fef;
    logic pef;
    logic [6:0] divider;
    logic [8:0] tx_hold;
    logic tx_pend;
    uart_chan_pkg::tx_state_type tx_st;
    logic [3:0] tx_cnt;
    logic txd;
    logic enable;
    logic [2:0] irq_mask;
    logic [2:0] irq_stat;
    logic [31:0] rdata;
  } state_type;
  state_type s_q, s_d;

  bit_timer_if rxt ();
  bit_timer_if txt ();
  logic [fw-1:0] rx_sr;
  logic [fw-1:0] tx_sr;
  logic rx_shift, tx_load, tx_shift;
  logic [fw-1:0] tx_frame;
  logic wr, rd, rd_setup, sync_now, par_err;
  logic ev_rx, ev_tx, ev_err;
  logic [8:0] wdata9;

  assign rxt.divider = s_q.divider;
  assign txt.divider = s_q.divider;

  bit_timer rx_timer (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .op_tick_i(op_tick_i), .t(rxt)
  );
  bit_timer tx_timer (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .op_tick_i(op_tick_i), .t(txt)
  );

  shift_frame #(.width(fw)) rx_shifter (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .load_i(1'b0), .load_data_i('0), .shift_i(rx_shift),
    .bit_i(s_q.rx_line), .data_o(rx_sr)
  );
  shift_frame #(.width(fw)) tx_shifter (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .load_i(tx_load), .load_data_i(tx_frame), .shift_i(tx_shift),
    .bit_i(1'b1), .data_o(tx_sr)
  );

  // ==========================================================
  // APB decode: zero wait states
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = s_q.rdata;
  assign txd_o = s_q.txd;
  assign irq_o = |(s_q.irq_stat & s_q.irq_mask);
  assign wdata9 = pwdata[8:0];
  assign par_err = parity_en && ((^rx_sr) != parity_odd);
  assign tx_frame = {parity_en ? (^s_q.tx_hold[data_bits-1:0] ^ parity_odd)
    : 1'b1, s_q.tx_hold[data_bits-1:0]};

  always_comb begin
    s_d = s_q;
    rxt.restart = 1'b0;
    txt.restart = 1'b0;
    rx_shift = 1'b0;
    tx_load = 1'b0;
    tx_shift = 1'b0;
    ev_rx = 1'b0;
    ev_tx = 1'b0;
    ev_err = 1'b0;
    // Three stages; a change counts once the last two agree
    s_d.rx_sync = {s_q.rx_sync[1:0], rxd_i};
    sync_now = (s_q.rx_sync[2] == s_q.rx_sync[1]);
    if (sync_now) begin
      s_d.rx_line = s_q.rx_sync[2];
    end

    // --------------------------------------------------------
    // Receive
    case (s_q.rx_st)
      uart_chan_pkg::rx_idle: begin
        if (s_q.enable && !s_q.rx_line) begin
          rxt.restart = 1'b1;
          s_d.rx_st = uart_chan_pkg::rx_start;
        end
      end
      uart_chan_pkg::rx_start: begin
        if (rxt.half_tick) begin
          // Sampling grid fixed by the divider from start edge
          if (s_q.rx_line) begin
            s_d.rx_st = uart_chan_pkg::rx_idle;
          end else begin
            s_d.rx_cnt = 4'h0;
            s_d.rx_st = uart_chan_pkg::rx_bits;
          end
        end
      end
      uart_chan_pkg::rx_bits: begin
        if (rxt.half_tick) begin
          rx_shift = 1'b1;
          s_d.rx_cnt = s_q.rx_cnt + 4'h1;
          if (s_q.rx_cnt == 4'(data_bits - (parity_en ? 0 : 1))) begin
            s_d.rx_st = uart_chan_pkg::rx_stop;
          end
        end
      end
      uart_chan_pkg::rx_stop: begin
        if (rxt.half_tick) begin
          // Stop bit must be high at the last sample point
          s_d.rx_st = uart_chan_pkg::rx_idle;
          ev_rx = 1'b1;
          s_d.rx_buf = 9'(parity_en ? rx_sr[fw-2:0] : rx_sr[fw-1:1]);
          if (s_q.full) begin
            s_d.ovf = 1'b1;
          end else begin
            s_d.full = 1'b1;
          end
          if (!s_q.rx_line) begin
            s_d.fef = 1'b1;
          end
          if (par_err) begin
            s_d.pef = 1'b1;
          end
        end
      end
      default: s_d.rx_st = uart_chan_pkg::rx_idle;
    endcase

    // --------------------------------------------------------
    // Transmit
    case (s_q.tx_st)
      uart_chan_pkg::tx_idle: begin
        s_d.txd = 1'b1;
        if (s_q.enable && s_q.tx_pend) begin
          tx_load = 1'b1;
          txt.restart = 1'b1;
          s_d.tx_pend = 1'b0;
          s_d.tx_cnt = 4'h0;
          s_d.txd = 1'b0;
          s_d.tx_st = uart_chan_pkg::tx_shift;
        end
      end
      uart_chan_pkg::tx_shift: begin
        // One bit per 2*(divider+1) operation clocks
        if (txt.tick) begin
          s_d.tx_cnt = s_q.tx_cnt + 4'h1;
          if (s_q.tx_cnt == 4'(fw + 1)) begin
            s_d.tx_st = uart_chan_pkg::tx_idle;
            ev_tx = 1'b1;
          end else if (s_q.tx_cnt == 4'(fw)) begin
            s_d.txd = 1'b1;
          end else begin
            // Each bit leaves the shifter as it goes on the line
            s_d.txd = tx_sr[0];
            tx_shift = 1'b1;
          end
        end
      end
      default: s_d.tx_st = uart_chan_pkg::tx_idle;
    endcase

    // --------------------------------------------------------
    // Register writes
    if (wr) begin
      case (paddr)
        uart_chan_pkg::data_divider_off: begin
          s_d.divider = pwdata[uart_chan_pkg::divider_msb:
            uart_chan_pkg::divider_lsb];
          s_d.tx_hold = wdata9;
          s_d.tx_pend = 1'b1;
        end
        uart_chan_pkg::flag_clear_off: begin
          // Ones clear; a new error in the same cycle wins
          if (pwdata[uart_chan_pkg::overrun_bit] && !(ev_rx && s_q.full))
            s_d.ovf = 1'b0;
          if (pwdata[uart_chan_pkg::framing_bit] && !(ev_rx && !s_q.rx_line))
            s_d.fef = 1'b0;
          if (pwdata[uart_chan_pkg::parity_bit] && !(ev_rx && par_err))
            s_d.pef = 1'b0;
        end
        uart_chan_pkg::start_off: begin
          if (pwdata[0]) begin
            s_d.enable = 1'b1;
          end
        end
        uart_chan_pkg::stop_off: begin
          if (pwdata[0]) begin
            s_d.enable = 1'b0;
            s_d.rx_st = uart_chan_pkg::rx_idle;
            s_d.tx_st = uart_chan_pkg::tx_idle;
            s_d.tx_pend = 1'b0;
            s_d.txd = 1'b1;
          end
        end
        uart_chan_pkg::irq_mask_off: s_d.irq_mask = pwdata[2:0];
        default: ;
      endcase
    end

    // --------------------------------------------------------
    // Register reads and interrupt status
    ev_err = ev_rx && (s_d.ovf | s_d.fef | s_d.pef);
    // Read data is captured in the setup cycle so it stands through
    // the access phase; side effects wait for the access edge
    if (rd_setup) begin
      s_d.rdata = 32'h0;
      case (paddr)
        uart_chan_pkg::data_divider_off: begin
          s_d.rdata[uart_chan_pkg::divider_msb:uart_chan_pkg::divider_lsb]
            = s_q.divider;
          s_d.rdata[8:0] = s_d.rx_buf;
        end
        uart_chan_pkg::status_off: begin
          s_d.rdata[uart_chan_pkg::overrun_bit] = s_q.ovf;
          s_d.rdata[uart_chan_pkg::framing_bit] = s_q.fef;
          s_d.rdata[uart_chan_pkg::parity_bit] = s_q.pef;
          s_d.rdata[uart_chan_pkg::full_bit] = s_q.full;
          s_d.rdata[uart_chan_pkg::tx_busy_bit] =
            s_q.tx_pend || (s_q.tx_st != uart_chan_pkg::tx_idle);
        end
        uart_chan_pkg::enable_status_off: s_d.rdata[0] = s_q.enable;
        uart_chan_pkg::irq_mask_off: s_d.rdata[2:0] = s_q.irq_mask;
        uart_chan_pkg::irq_status_off: s_d.rdata[2:0] = s_q.irq_stat;
        default: ;
      endcase
    end
    if (rd) begin
      case (paddr)
        uart_chan_pkg::data_divider_off: begin
          // Read frees the buffer so a next frame does not overrun
          if (!ev_rx) begin
            s_d.full = 1'b0;
          end
        end
        uart_chan_pkg::irq_status_off: begin
          // Only bits already reported are cleared; later events stay
          s_d.irq_stat = s_q.irq_stat & ~s_q.rdata[2:0];
        end
        default: ;
      endcase
    end
    // Events win over the read clear
    if (ev_rx) s_d.irq_stat[uart_chan_pkg::irq_rx_bit] = 1'b1;
    if (ev_tx) s_d.irq_stat[uart_chan_pkg::irq_tx_bit] = 1'b1;
    if (ev_err) s_d.irq_stat[uart_chan_pkg::irq_err_bit] = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.rx_sync <= 3'h7;
      s_q.rx_line <= 1'b1;
      s_q.txd <= 1'b1;
      s_q.divider <= uart_chan_pkg::divider_reset;
      s_q.enable <= uart_chan_pkg::enable_reset;
      s_q.irq_mask <= uart_chan_pkg::irq_mask_reset;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ---- serial_peer.sv ----
// Remote serial party: sends frames on rxd, captures frames from txd.
// Assumes idle-high lines, 8 data bits, even parity, one stop bit.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  // ==========================================================
  // Transmit side; the line rests high between frames
  logic [9:0] got_q;
  int frames_q = 0;
  int bit_cyc = 42;
  initial rxd_o = 1'b1;
  task automatic send(input logic [7:0] b, input bit bad_par,
    input bit bad_stop, input int cyc);
    logic [10:0] f;
    f = {~bad_stop, (^b) ^ bad_par, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_o <= f[i];
      repeat (cyc) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    @(posedge clk_i);
  endtask
  // ==========================================================
  // Receive side, sampled at mid bit
  always begin
    @(negedge txd_i);
    repeat (bit_cyc / 2) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      repeat (bit_cyc) @(posedge clk_i);
      got_q[i] = txd_i;
    end
    frames_q++;
  end
endmodule
`default_nettype wire

// ---- uart_chan_asserts.sv ----
// Checker of the channel's port behaviour.
// Assumes ce_i and op_tick_i stay high, so a bit is 2*(div+1) clocks.
`timescale 1ns/1ps
`default_nettype none
module uart_chan_asserts (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic op_tick_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd_i,
  input wire logic txd_o,
  input wire logic irq_o
);
  // ==========================================================
  // Shadow of software settings
  logic wr, rd, en_q, txd_q;
  logic [6:0] div_q;
  logic [2:0] mask_q;
  logic [15:0] run_q;
  assign wr = psel & penable & pready & pwrite;
  assign rd = psel & penable & pready & !pwrite;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= uart_chan_pkg::divider_reset;
      mask_q <= uart_chan_pkg::irq_mask_reset;
      en_q <= uart_chan_pkg::enable_reset;
      txd_q <= 1'b1;
      run_q <= 16'h0;
    end else begin
      txd_q <= txd_o;
      run_q <= (txd_o != txd_q) ? 16'h1 : run_q + 16'h1;
      if (wr && paddr == 8'h00) div_q <= pwdata[15:9];
      if (wr && paddr == 8'h18) mask_q <= pwdata[2:0];
      if (wr && paddr == 8'h0c && pwdata[0]) en_q <= 1'b1;
      if (wr && paddr == 8'h10 && pwdata[0]) en_q <= 1'b0;
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence rd_at(logic [7:0] a);
    rd && paddr == a;
  endsequence
  // One cycle of grace: a stop may land in mid frame
  sequence halted;
    !en_q [*2];
  endsequence
  a_ready_high: assert property (psel |-> pready && !pslverr)
    else $error("ready low or error raised");
  a_div_readback: assert property (
    rd_at(8'h00) |-> prdata[15:9] == div_q)
    else $error("divider readback wrong");
  a_enable_readback: assert property (
    rd_at(8'h14) |-> prdata[0] == en_q)
    else $error("enable status wrong");
  a_unmapped_zero: assert property (rd && paddr >= 8'h20 |-> prdata == 0)
    else $error("unmapped read not zero");
  a_prdata_holds: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  a_bit_time: assert property (
    $rose(txd_o) |-> run_q % (2 * (div_q + 1)) == 0)
    else $error("low run not a whole bit count");
  a_halted_quiet: assert property (halted |-> txd_o)
    else $error("line active while halted");
  a_irq_masked: assert property (mask_q == 3'h0 |-> !irq_o)
    else $error("interrupt with all masked");
endmodule
bind uart_chan uart_chan_asserts uart_chan_asserts_i (.clk_i, .rst_b_i,
  .ce_i, .op_tick_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .rxd_i, .txd_o, .irq_o);
`default_nettype wire

// ---- tb_top.sv ----
// Testbench: APB traffic plus frames through the serial peer.
// Assumes the package, checker and peer are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // Signals
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_q;
  logic pready, pslverr, rxd, txd, irq;
  logic [31:0] seed = 32'h14f39;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int rate[3] = '{41, 43, 42};
  // Small divider keeps frames short, still room for a 2% offset
  localparam logic [6:0] div = 7'h14;
  uart_chan uart_chan_i (.clk_i, .rst_b_i, .ce_i(1'b1), .op_tick_i(1'b1),
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rxd_i(rxd), .txd_o(txd), .irq_o(irq));
  serial_peer serial_peer_i (.clk_i, .txd_i(txd), .rxd_o(rxd));
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      end_sim();
    end
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int bit_clks(input logic [6:0] d);
    return 2 * (d + 1);
  endfunction
  task automatic end_sim();
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e,
    input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // Read data stands in the access phase and is taken at its edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd_q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_irq();
    int n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    cmp("irq_wait", 32'h1, irq);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] st;
    int f;
    serial_peer_i.bit_cyc = bit_clks(div);
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    apb(0, 8'h00, 32'h0);
    cmp("div", 32'h4d, rd_q[15:9]);
    apb(0, 8'h14, 32'h0);
    cmp("en", 32'h0, rd_q[0]);
    apb(0, 8'h20, 32'h0);
    cmp("unmapped", 32'h0, rd_q);
    apb(1, 8'h18, 32'h7);
    apb(1, 8'h0c, 32'h1);
    apb(0, 8'h14, 32'h0);
    cmp("en", 32'h1, rd_q[0]);
    for (int i = 0; i < 4; i++) begin
      st = rnd();
      if (i < 2) st = {32{i[0]}};
      f = serial_peer_i.frames_q;
      apb(1, 8'h00, {16'h0, div, 1'b0, st[7:0]});
      while (serial_peer_i.frames_q == f) @(posedge clk_i);
      cmp("tx", {^st[7:0], st[7:0]}, serial_peer_i.got_q[8:0]);
      cmp("stop", 32'h1, serial_peer_i.got_q[9]);
    end
    repeat (bit_clks(div)) @(posedge clk_i);
    apb(0, 8'h1c, 32'h0);
    foreach (rate[i]) begin
      st = rnd();
      serial_peer_i.send(st[7:0], 1'b0, 1'b0, rate[i]);
      wait_irq();
      apb(0, 8'h04, 32'h0);
      cmp("full", 32'h20, rd_q & 32'h27);
      apb(0, 8'h00, 32'h0);
      cmp("rx", st[7:0], rd_q[7:0]);
      apb(0, 8'h04, 32'h0);
      cmp("full", 32'h0, rd_q[5]);
      apb(0, 8'h1c, 32'h0);
      cmp("irq", 32'h0, irq);
    end
    serial_peer_i.send(8'h5a, 1'b1, 1'b0, 42);
    serial_peer_i.send(8'ha5, 1'b0, 1'b0, 42);
    wait_irq();
    apb(0, 8'h00, 32'h0);
    apb(0, 8'h04, 32'h0);
    st = rd_q;
    cmp("par ovr", 32'h5, st[2:0]);
    apb(1, 8'h08, st);
    apb(0, 8'h04, 32'h0);
    cmp("errs", 32'h0, rd_q[2:0]);
    apb(0, 8'h1c, 32'h0);
    serial_peer_i.send(8'h3c, 1'b0, 1'b1, 42);
    wait_irq();
    apb(1, 8'h18, 32'h0);
    cmp("masked", 32'h0, irq);
    apb(1, 8'h18, 32'h7);
    cmp("unmasked", 32'h1, irq);
    apb(0, 8'h00, 32'h0);
    apb(0, 8'h04, 32'h0);
    st = rd_q;
    cmp("framing", 32'h1, st[1]);
    apb(1, 8'h08, st);
    apb(1, 8'h10, 32'h1);
    apb(0, 8'h14, 32'h0);
    cmp("en", 32'h0, rd_q[0]);
    f = serial_peer_i.frames_q;
    apb(1, 8'h00, {16'h0, div, 9'h0c3});
    repeat (11 * bit_clks(div)) @(posedge clk_i);
    cmp("halted", f, serial_peer_i.frames_q);
    apb(1, 8'h0c, 32'h1);
    apb(0, 8'h14, 32'h0);
    cmp("en", 32'h1, rd_q[0]);
    end_sim();
  end
endmodule
`default_nettype wire
